// File: rtl/sleep_clock_pkg.sv
// What this block does
// - writing 00 to the mode field enters sleep at once, ignoring auto-sleep.
// - mode field reads present mode; 00 sleep, 01 operation, resets to 01.
// - entering sleep from operation switches off all active pwm outputs.
// - clock gate bit 2 runs pwm timers 0..2 together; resets to 0.
// - clock gate bit 0 runs the keypad scanner clock; resets to 0.
// - each clock gate bit acts on its own unit only.
// - auto-sleep bit 0 arms automatic sleep; resets to 0.
// - armed and idle timeout elapsed without events enters sleep.
// - idle timeout is 11 bits in 4 ms steps, split low and high.
// - idle timeout zero disables automatic sleep entirely.
// - idle timeout resets to 0xff, 1020 ms.
package sleep_clock_pkg;
  localparam logic [7:0] OFS_MODE     = 8'h88;
  localparam logic [7:0] OFS_CLKGATE  = 8'h8a;
  localparam logic [7:0] OFS_AUTO_SLEEP_ARM  = 8'h8b;
  localparam logic [7:0] OFS_TMO_LOW  = 8'h8c;
  localparam logic [7:0] OFS_TMO_HIGH = 8'h8d;
  localparam int         BIT_KEYSCAN  = 0;
  localparam int         BIT_PWM      = 2;
  localparam int         BIT_ARM      = 0;
  localparam logic [1:0] MODE_SLEEP   = 2'h0;
  localparam logic [1:0] MODE_RUN     = 2'h1;
  localparam logic [1:0] RST_MODE     = 2'h1;
  localparam logic [7:0] RST_TMO_LOW  = 8'hff;
  localparam logic [2:0] RST_TMO_HIGH = 3'h0;
  localparam int         STEP_MS      = 4;
  localparam int         CLK_KHZ      = 20000;
  localparam int         STEP_CYCLES  = STEP_MS * CLK_KHZ;
endpackage

// File: rtl/sleep_mode_clock_gating.sv
`timescale 1ns/1ps
module sleep_mode_clock_gating
  import sleep_clock_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       procEvent,
  output logic            sleepMode,
  output logic            keyscanClockOn,
  output logic            pwmTimerClockOn,
  output logic            pwmOff
);
  // divider counter is 24 bits wide
  if (STEP_CYC < 1 || STEP_CYC > 16777215) begin : g_bad_step
    $error("STEP_CYC out of range");
  end

  // ==========================================================
  // reset release
  logic rstMeta;
  logic rstSync_b;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta   <= 1'b0;
      rstSync_b <= 1'b0;
    end else begin
      rstMeta   <= 1'b1;
      rstSync_b <= rstMeta;
    end
  end

  // ==========================================================
  // registers
  logic [1:0]  operatingModeField;
  logic [2:0]  unitClockGate;
  logic        autoSleepControl;
  logic [10:0] idleTimeout;
  logic        autoExpire;
  logic        wrMode;
  logic        cfgChange;
  assign wrMode = regWrite && regAddr == OFS_MODE;
  assign cfgChange = regWrite && (regAddr == OFS_AUTO_SLEEP_ARM
    || regAddr == OFS_TMO_LOW || regAddr == OFS_TMO_HIGH);

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      operatingModeField <= RST_MODE;
    end else if (wrMode && regWdata[1:0] == MODE_SLEEP) begin
      operatingModeField <= MODE_SLEEP;
    end else if (wrMode) begin
      // reserved codes are not kept
      if (regWdata[1:0] == MODE_RUN)
        operatingModeField <= MODE_RUN;
    end else if (autoExpire) begin
      operatingModeField <= MODE_SLEEP;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      unitClockGate    <= 3'h0;
      autoSleepControl <= 1'b0;
      idleTimeout      <= {RST_TMO_HIGH, RST_TMO_LOW};
    end else if (regWrite) begin
      unique case (regAddr)
        OFS_CLKGATE: begin
          // each bit only its own unit
          unitClockGate[BIT_PWM]     <= regWdata[BIT_PWM];
          unitClockGate[BIT_KEYSCAN] <= regWdata[BIT_KEYSCAN];
        end
        OFS_AUTO_SLEEP_ARM:  autoSleepControl   <= regWdata[BIT_ARM];
        OFS_TMO_LOW:  idleTimeout[7:0]   <= regWdata;
        OFS_TMO_HIGH: idleTimeout[10:8]  <= regWdata[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // 4 ms tick divider
  logic [23:0] divCount;
  logic        tick;
  assign tick = divCount == 24'(STEP_CYC - 1);
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b)
      divCount <= 24'h0;
    else if (tick || procEvent || cfgChange)
      divCount <= 24'h0;
    else
      divCount <= divCount + 24'h1;
  end

  // ==========================================================
  // idle counter
  logic [10:0] idleLeft;
  logic        sleeping;
  assign sleeping = operatingModeField == MODE_SLEEP;
  assign autoExpire = autoSleepControl && idleTimeout != 11'h0
    && !sleeping && tick && idleLeft == 11'h1;
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b)
      idleLeft <= {RST_TMO_HIGH, RST_TMO_LOW};
    else if (procEvent || cfgChange || sleeping)
      idleLeft <= idleTimeout;
    else if (tick && idleLeft != 11'h0)
      idleLeft <= idleLeft - 11'h1;
  end

  // ==========================================================
  // outputs
  logic prevSleep;
  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b) begin
      prevSleep <= 1'b0;
      pwmOff    <= 1'b0;
    end else begin
      prevSleep <= sleeping;
      pwmOff    <= sleeping && !prevSleep;
    end
  end
  assign sleepMode       = sleeping;
  // gated units stop while asleep as well
  assign pwmTimerClockOn = unitClockGate[BIT_PWM] && !sleeping;
  assign keyscanClockOn  = unitClockGate[BIT_KEYSCAN] && !sleeping;

  always_ff @(posedge clk_sys or negedge rstSync_b) begin
    if (!rstSync_b)
      regRdata <= 8'h0;
    else if (regRead) begin
      unique case (regAddr)
        OFS_MODE:     regRdata <= {6'h0, operatingModeField};
        OFS_CLKGATE:  regRdata <= {5'h0, unitClockGate};
        OFS_AUTO_SLEEP_ARM:  regRdata <= {7'h0, autoSleepControl};
        OFS_TMO_LOW:  regRdata <= idleTimeout[7:0];
        OFS_TMO_HIGH: regRdata <= {5'h0, idleTimeout[10:8]};
        default:      regRdata <= 8'h0;
      endcase
    end
  end
endmodule

// File: verification/sleep_mode_clock_gating_props.sv
`timescale 1ns/1ps
module sleep_mode_clock_gating_props
  import sleep_clock_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       sleepMode,
  input wire logic       keyscanClockOn,
  input wire logic       pwmTimerClockOn,
  input wire logic       pwmOff
);
  // ======
  // mode and gating
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic wm;
  assign wm = regWrite && regAddr == OFS_MODE;
  sequence s_sl; !sleepMode ##1 sleepMode; endsequence
  property p_sl; wm && regWdata[1:0] == MODE_SLEEP |=> sleepMode; endproperty
  a_sl: assert property (p_sl) else $error("no sleep");
  property p_of; s_sl |=> pwmOff; endproperty
  a_of: assert property (p_of) else $error("no pwm off");
  property p_pu; pwmOff |=> !pwmOff; endproperty
  a_pu: assert property (p_pu) else $error("long pwm off");
  property p_gt; sleepMode |-> !keyscanClockOn && !pwmTimerClockOn; endproperty
  a_gt: assert property (p_gt) else $error("clock on in sleep");
  property p_ce; regWrite && regAddr == OFS_CLKGATE |=> sleepMode ||
    keyscanClockOn == $past(regWdata[BIT_KEYSCAN]) &&
    pwmTimerClockOn == $past(regWdata[BIT_PWM]); endproperty
  a_ce: assert property (p_ce) else $error("gate");
  property p_wk; wm && regWdata[1:0] == MODE_RUN |=> !sleepMode; endproperty
  a_wk: assert property (p_wk) else $error("no wake");
  property p_fl;
    $fell(sleepMode) |-> $past(wm && regWdata[1:0] == MODE_RUN); endproperty
  a_fl: assert property (p_fl) else $error("odd wake");
  property p_rd; regRead && !regWrite && regAddr == OFS_MODE |=>
    regRdata == {7'h0, !$past(sleepMode)}; endproperty
  a_rd: assert property (p_rd) else $error("mode read");
endmodule
bind sleep_mode_clock_gating sleep_mode_clock_gating_props i_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .regWrite(regWrite),
  .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
  .regRdata(regRdata), .sleepMode(sleepMode), .pwmOff(pwmOff),
  .keyscanClockOn(keyscanClockOn), .pwmTimerClockOn(pwmTimerClockOn));

// File: verification/sleep_mode_clock_gating_bench.sv
`timescale 1ns/1ps
module sleep_mode_clock_gating_bench;
  // ======
  // stimulus and checks
  logic       clk_sys = 0, rst_b = 0, regWrite = 0, regRead = 0, procEvent = 0;
  logic [7:0] regAddr = 0, regWdata = 0, regRdata, dv, rdq[$];
  logic       sleepMode, keyscanClockOn, pwmTimerClockOn, pwmOff, rdSeen = 0;
  int         fails = 0, compares = 0, offs = 0;
  always #25 clk_sys = ~clk_sys;
  sleep_mode_clock_gating #(.STEP_CYC(4)) i_sleep_mode_clock_gating (
    .clk_sys(clk_sys), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .procEvent(procEvent), .sleepMode(sleepMode), .pwmOff(pwmOff),
    .keyscanClockOn(keyscanClockOn), .pwmTimerClockOn(pwmTimerClockOn));
  task chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task results;
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= w;
    regRead <= !w;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWrite <= 0;
    regRead <= 0;
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    rdq.push_back(e);
    acc(0, a, 0);
  endtask
  task pins(int n, logic [2:0] e);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("pins", 8'(e), 8'({keyscanClockOn, pwmTimerClockOn, sleepMode}));
  endtask
  // read data answers one cycle after the strobe edge
  always @(posedge clk_sys) rdSeen <= regRead;
  always @(negedge clk_sys) begin
    if (rdSeen) chk("rdata", rdq.pop_front(), regRdata);
    if (pwmOff === 1'b1) offs++;
  end
  initial begin
    #200us;
    fails++;
    results;
  end
  initial begin
    void'($urandom(32'h984622a0));
    repeat (12) @(posedge clk_sys);
    rst_b <= 1;
    repeat (3) @(posedge clk_sys);
    rd(8'h88, 8'h01);
    rd(8'h8a, 8'h00);
    rd(8'h8b, 8'h00);
    rd(8'h8c, 8'hff);
    rd(8'h8d, 8'h00);
    repeat (4) begin
      dv = 8'($urandom);
      acc(1, 8'h8a, dv);
      pins(0, {dv[0], dv[2], 1'b0});
    end
    rd(8'h8a, dv & 8'h05);
    acc(1, 8'h8a, 8'h05);
    acc(1, 8'h88, 8'h02);
    rd(8'h88, 8'h01);
    acc(1, 8'h88, 8'h00);
    pins(1, 3'b001);
    rd(8'h88, 8'h00);
    chk("pwmoff", 8'h01, 8'(offs));
    acc(1, 8'h88, 8'h01);
    acc(1, 8'h8c, 8'h03);
    acc(1, 8'h8b, 8'h01);
    procEvent <= 1;
    pins(60, 3'b110);
    @(posedge clk_sys);
    procEvent <= 0;
    pins(20, 3'b001);
    acc(1, 8'h8b, 8'h00);
    acc(1, 8'h88, 8'h01);
    acc(1, 8'h8c, 8'h00);
    acc(1, 8'h8d, 8'h01);
    acc(1, 8'h8b, 8'h01);
    pins(900, 3'b110);
    pins(200, 3'b001);
    acc(1, 8'h88, 8'h01);
    acc(1, 8'h8d, 8'h00);
    pins(60, 3'b110);
    acc(1, 8'h8b, 8'h00);
    acc(1, 8'h8c, 8'h01);
    pins(60, 3'b110);
    results;
  end
endmodule
